// file: common/pid_reg_pkg.sv
/*
  Constants, register map, scaling and sequencer states of the process
  PID regulator. Assumes a 100 MHz clock and a 32-bit APB register bus.
*/
package pid_reg_pkg;

  // Wide signed arithmetic type for products and the integral store
  typedef logic signed [47:0] wide_t;

  // Sequencer that walks the regulator chain once per sample
  typedef enum logic [2:0] {
    S_IDLE, S_RAMP_LD, S_RAMP_DV, S_INT_LD, S_INT_DV, S_FLT_LD, S_FLT_DV, S_OUT
  } seq_state_t;

  // Clock and control sample period
  localparam int CLOCK_PERIOD_NS   = 10;
  localparam int SAMPLE_TIME_NS    = 1000000;
  localparam int SAMPLE_CYCLES_DOC = SAMPLE_TIME_NS / CLOCK_PERIOD_NS;

  // Configuration word indices; byte address is four times the index
  localparam int CFG_COUNT     = 19;
  localparam int IDX_TGT_SRC   = 0;
  localparam int IDX_FB_SRC    = 1;
  localparam int IDX_CMD_SEL   = 2;
  localparam int IDX_MODE      = 3;
  localparam int IDX_TARGET    = 4;
  localparam int IDX_FB_GAIN   = 5;
  localparam int IDX_KP        = 6;
  localparam int IDX_TI        = 7;
  localparam int IDX_TD        = 8;
  localparam int IDX_BIAS      = 9;
  localparam int IDX_FILT      = 10;
  localparam int IDX_ILIM      = 11;
  localparam int IDX_OLIM      = 12;
  localparam int IDX_OUT_GAIN  = 13;
  localparam int IDX_REV_SEL   = 14;
  localparam int IDX_RAMP      = 15;
  localparam int IDX_LOSS_SEL  = 16;
  localparam int IDX_LOSS_LVL  = 17;
  localparam int IDX_LOSS_TIME = 18;

  localparam logic [15:0] CFG_RESET [CFG_COUNT] = '{
    16'h0001, 16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0064,
    16'h000a, 16'h0000, 16'h0000, 16'h0000, 16'h03e8, 16'h2710, 16'h000a,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h000a
  };

  // Byte addresses
  localparam logic [11:0] ADDR_CFG_END = 12'h04c;
  localparam logic [11:0] ADDR_STATUS  = 12'h050;
  localparam logic [11:0] ADDR_OUTPUT  = 12'h054;
  localparam logic [11:0] ADDR_FEEDBK  = 12'h058;

  // Status word bit positions
  localparam int ST_REVERSE  = 0;
  localparam int ST_ACTIVE   = 1;
  localparam int ST_CONFLICT = 2;
  localparam int ST_LOSS     = 3;
  localparam int ST_FAULT    = 4;

  // Control mode bits
  localparam int MODE_ENABLE = 0;
  localparam int MODE_NEG    = 1;
  localparam int MODE_D_FB   = 2;
  localparam int MODE_ADD    = 3;

  // Selector codes
  localparam logic [15:0] SRC_AIN_ONE  = 16'h0001;
  localparam logic [15:0] SRC_AIN_TWO  = 16'h0002;
  localparam logic [15:0] SRC_INTERNAL = 16'h0004;
  localparam logic [15:0] CMD_SEL_PID  = 16'h0005;
  localparam logic [15:0] LOSS_OFF     = 16'h0000;
  localparam logic [15:0] LOSS_FAULT   = 16'h0002;
  localparam logic [15:0] REV_ALLOW    = 16'h0001;

  // Scaling: process values in 0.01 % units, 10000 is full scale
  localparam int PCT_FULL       = 10000;
  localparam int TENTH_PCT      = 10;
  localparam int WHOLE_PCT      = 100;
  localparam int GAIN_DIV       = 100;
  localparam int OGAIN_DIV      = 10;
  localparam int TI_SAMPLES     = 100;
  localparam int TD_SAMPLES     = 10;
  localparam int FLT_SAMPLES    = 10;
  localparam int LOSS_SAMPLES   = 100;
  localparam int RAMP_FRAC      = 8;
  localparam int RAMP_DIVIDEND  = 25600;
  localparam int DIV_W          = 48;

endpackage

// file: logic/process_pid_regulator.sv
/*
  Process PID regulator with APB register file: target select and ramp,
  feedback scaling, P, clamped I and D paths, output limit, first-order
  filter, bias and output gain, negative output handling, feedback loss.
  Assumes analog inputs and the frequency reference arrive synchronous to
  clock as unsigned 0.01 % values, and an APB master on the bus side.
*/
`timescale 1ns/1ps

// Functional notes
// - Target source: code 1 input one, 2 input two, 4 internal setting.
// - Apart from the conflict alarm, target selection only matters while frequency command selection is 5.
// - Same feedback and target source raises the conflict alarm.
// - Mode bit 0 enables the regulator.
// - Mode bit 1 selects negative characteristic.
// - Mode bit 2 selects derivative of feedback instead of error.
// - Mode bit 3 adds the target to the regulator output.
// - Feedback is scaled by feedback gain, subtracted from target.
// - Proportional path multiplies error by proportional gain.
// - Integral path integrates error over integral time.
// - Integral output clamped to the integral limit.
// - Derivative path multiplies rate of change by differential time.
// - Summed output clamped by the output limit.
// - First-order low-pass filter follows the output limit.
// - Bias added as compensation, scaled by output gain.
// - Negative output reverses direction if allowed, else held at zero.
// - Target ramped by soft ramp time, bypassed by ramp bypass input.
// - Feedback loss selection: off, warning or fault; level and time.
// - Loss declared when feedback stays below level for detection time.
// - Warning keeps running; fault stops output and raises fault contact.
module process_pid_regulator
  import pid_reg_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DOC
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] analogInputOne,
  input  wire logic [15:0] analogInputTwo,
  input  wire logic [15:0] freqRefIn,
  input  wire logic        rampBypass,
  output logic      [15:0] freqRefOut,
  output logic             reverseCmd,
  output logic             sourceConflictAlarm,
  output logic             feedbackLossIndication,
  output logic             feedbackLossFault
);

  logic        [15:0] cfg_ff [CFG_COUNT];
  logic        [31:0] prdata_ff;
  logic               pready_ff;
  logic               pslverr_ff;
  logic        [31:0] rdValue;
  logic               addrHit;
  logic               wrEn;
  logic               faultClear;
  logic        [4:0]  cfgIdx;
  logic               conflict;
  logic               active;
  logic        [15:0] tgtSel;
  logic        [15:0] fbSel;
  seq_state_t         state_ff;
  logic        [31:0] tick_ff;
  logic               tick;
  logic [DIV_W-1:0]   quot_ff;
  logic [DIV_W:0]     rem_ff;
  logic [DIV_W-1:0]   divisor_ff;
  logic        [5:0]  divCnt_ff;
  logic               divBusy_ff;
  logic               divLoad;
  logic [DIV_W-1:0]   divA;
  logic [DIV_W-1:0]   divB;
  logic [DIV_W:0]     remShift;
  logic        [15:0] tgtSnap_ff;
  logic        [15:0] fbSnap_ff;
  logic signed [31:0] softRampAcc_ff;
  wide_t              integAcc_ff;
  logic signed [31:0] iTerm_ff;
  logic signed [31:0] dPrev_ff;
  logic signed [31:0] flt_ff;
  logic signed [31:0] tgtNow;
  logic signed [31:0] fbScaled;
  logic signed [31:0] err;
  logic signed [31:0] dIn;
  logic signed [31:0] pTerm;
  logic signed [31:0] dTerm;
  logic signed [31:0] limited;
  logic signed [31:0] fltDiff;
  logic signed [31:0] rampDiff;
  logic signed [31:0] outValue;
  wide_t              accNext;
  wide_t              accMax;
  logic        [15:0] freqRefOut_ff;
  logic               reverse_ff;
  logic               conflict_ff;
  logic               lossInd_ff;
  logic               lossFault_ff;
  logic        [31:0] lossCnt_ff;
  logic               lossBelow;
  logic               lossHit;

  // Saturate a wide value to plus or minus a non-negative limit
  function automatic logic signed [31:0] sat(input wide_t v, input wide_t lim);
    wide_t r;
    r = v;
    if (v > lim) begin
      r = lim;
    end else if (v < -lim) begin
      r = -lim;
    end
    return 32'(r);
  endfunction

  // Register decode, one read data word per access, answered after one wait state
  always_comb begin
    rdValue = 32'h0000_0000;
    addrHit = 1'b0;
    cfgIdx  = paddr[6:2];
    if (paddr[1:0] != 2'h0) begin
      addrHit = 1'b0;
    end else if (paddr < ADDR_CFG_END) begin
      addrHit = 1'b1;
      rdValue = {16'h0000, cfg_ff[cfgIdx]};
    end else if (paddr == ADDR_STATUS) begin
      addrHit = 1'b1;
      rdValue = {27'h0, lossFault_ff, lossInd_ff, conflict_ff, active, reverse_ff};
    end else if (paddr == ADDR_OUTPUT) begin
      addrHit = 1'b1;
      rdValue = {16'h0000, freqRefOut_ff};
    end else if (paddr == ADDR_FEEDBK) begin
      addrHit = 1'b1;
      rdValue = fbScaled;
    end
  end

  // Writes land on the edge that completes the access, as the master sees it
  assign wrEn       = psel && penable && pready_ff && pwrite && addrHit;
  assign faultClear = wrEn && (paddr == ADDR_STATUS) && pwdata[ST_FAULT];

  // APB handshake: one wait state, error on unmapped or misaligned address
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel && penable && !pready_ff;
      prdata_ff  <= (psel && penable && !pready_ff && !pwrite) ? rdValue : 32'h0000_0000;
      pslverr_ff <= psel && penable && !pready_ff && !addrHit;
    end
  end

  // Configuration store; only the configuration words take writes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < CFG_COUNT; i++) begin
        cfg_ff[i] <= CFG_RESET[i];
      end
    end else if (wrEn && (paddr < ADDR_CFG_END)) begin
      cfg_ff[cfgIdx] <= pwdata[15:0];
    end
  end

  // Source selection and the conditions that let the regulator run
  assign conflict = (cfg_ff[IDX_TGT_SRC] == cfg_ff[IDX_FB_SRC]);
  assign active   = cfg_ff[IDX_MODE][MODE_ENABLE]
                    && (cfg_ff[IDX_CMD_SEL] == CMD_SEL_PID)
                    && !conflict;

  always_comb begin
    tgtSel = 16'h0000; // Reserved and unknown codes give a zero target
    if (cfg_ff[IDX_TGT_SRC] == SRC_AIN_ONE) begin
      tgtSel = analogInputOne;
    end else if (cfg_ff[IDX_TGT_SRC] == SRC_AIN_TWO) begin
      tgtSel = analogInputTwo;
    end else if (cfg_ff[IDX_TGT_SRC] == SRC_INTERNAL) begin
      tgtSel = 16'(cfg_ff[IDX_TARGET] * TENTH_PCT);
    end
    fbSel = 16'h0000;
    if (cfg_ff[IDX_FB_SRC] == SRC_AIN_ONE) begin
      fbSel = analogInputOne;
    end else if (cfg_ff[IDX_FB_SRC] == SRC_AIN_TWO) begin
      fbSel = analogInputTwo;
    end
  end

  // Sample tick; a fixed period keeps the I and D scaling exact
  assign tick = (tick_ff == 32'(SAMPLE_CYCLES - 1));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tick_ff <= 32'h0000_0000;
    end else if (tick) begin
      tick_ff <= 32'h0000_0000;
    end else begin
      tick_ff <= tick_ff + 32'h0000_0001;
    end
  end

  // Arithmetic of the chain, all from the sample snapshot
  assign tgtNow   = softRampAcc_ff >>> RAMP_FRAC;
  assign fbScaled = 32'(($signed({32'h0, fbSnap_ff}) * $signed({32'h0, cfg_ff[IDX_FB_GAIN]}))
                        / GAIN_DIV);
  assign err      = cfg_ff[IDX_MODE][MODE_NEG] ? (fbScaled - tgtNow)
                                               : (tgtNow - fbScaled);
  assign dIn      = !cfg_ff[IDX_MODE][MODE_D_FB] ? err
                    : (cfg_ff[IDX_MODE][MODE_NEG] ? fbScaled : -fbScaled);
  assign pTerm    = 32'((wide_t'(err) * $signed({32'h0, cfg_ff[IDX_KP]})) / GAIN_DIV);
  assign dTerm    = sat(wide_t'(dIn - dPrev_ff) * $signed({32'h0, cfg_ff[IDX_TD]})
                        * TD_SAMPLES, wide_t'(PCT_FULL));
  assign accMax   = $signed({32'h0, cfg_ff[IDX_ILIM]}) * TENTH_PCT
                    * $signed({32'h0, cfg_ff[IDX_TI]}) * TI_SAMPLES;
  assign accNext  = wide_t'(sat(integAcc_ff + wide_t'(err), accMax));
  assign limited  = sat(wide_t'(pTerm) + wide_t'(iTerm_ff) + wide_t'(dTerm),
                        $signed({32'h0, cfg_ff[IDX_OLIM]}));
  assign fltDiff  = limited - flt_ff;
  assign rampDiff = ($signed({16'h0000, tgtSnap_ff}) <<< RAMP_FRAC) - softRampAcc_ff;

  // Output stage: bias, output gain, optional target, full-scale clamp
  always_comb begin
    wide_t x;
    x = wide_t'(flt_ff) + wide_t'($signed(cfg_ff[IDX_BIAS])) * WHOLE_PCT;
    x = (x * $signed({32'h0, cfg_ff[IDX_OUT_GAIN]})) / OGAIN_DIV;
    if (cfg_ff[IDX_MODE][MODE_ADD]) begin
      x = x + wide_t'(tgtNow);
    end
    outValue = sat(x, wide_t'(PCT_FULL));
  end

  // Divider operands for the stage being loaded
  always_comb begin
    divLoad = 1'b0;
    divA    = '0;
    divB    = '0;
    case (state_ff)
      S_RAMP_LD: begin
        divLoad = !(rampBypass || cfg_ff[IDX_RAMP] == 16'h0000);
        divA    = DIV_W'(RAMP_DIVIDEND);
        divB    = DIV_W'(cfg_ff[IDX_RAMP]);
      end
      S_INT_LD: begin
        divLoad = (cfg_ff[IDX_TI] != 16'h0000);
        divA    = accNext < 0 ? DIV_W'(-accNext) : DIV_W'(accNext);
        divB    = DIV_W'(cfg_ff[IDX_TI] * TI_SAMPLES);
      end
      S_FLT_LD: begin
        divLoad = (cfg_ff[IDX_FILT] != 16'h0000);
        divA    = fltDiff < 0 ? DIV_W'(-fltDiff) : DIV_W'(fltDiff);
        divB    = DIV_W'(cfg_ff[IDX_FILT] * FLT_SAMPLES + 1);
      end
      default: begin
        divLoad = 1'b0;
      end
    endcase
  end

  // Restoring divider shared by ramp, integral and filter; one bit a cycle
  assign remShift = {rem_ff[DIV_W-1:0], quot_ff[DIV_W-1]};

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      quot_ff    <= '0;
      rem_ff     <= '0;
      divisor_ff <= '0;
      divCnt_ff  <= 6'h00;
      divBusy_ff <= 1'b0;
    end else if (divLoad) begin
      quot_ff    <= divA;
      rem_ff     <= '0;
      divisor_ff <= divB;
      divCnt_ff  <= 6'(DIV_W);
      divBusy_ff <= 1'b1;
    end else if (divBusy_ff) begin
      if (remShift >= {1'b0, divisor_ff}) begin
        rem_ff  <= remShift - {1'b0, divisor_ff};
        quot_ff <= {quot_ff[DIV_W-2:0], 1'b1};
      end else begin
        rem_ff  <= remShift;
        quot_ff <= {quot_ff[DIV_W-2:0], 1'b0};
      end
      divCnt_ff  <= divCnt_ff - 6'h01;
      divBusy_ff <= (divCnt_ff != 6'h01);
    end
  end

  // Sequencer: one pass of the chain per sample tick
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= S_IDLE;
    end else if (!active) begin
      state_ff <= S_IDLE;
    end else begin
      case (state_ff)
        S_IDLE:    state_ff <= tick ? S_RAMP_LD : S_IDLE;
        S_RAMP_LD: state_ff <= divLoad ? S_RAMP_DV : S_INT_LD;
        S_RAMP_DV: state_ff <= divBusy_ff ? S_RAMP_DV : S_INT_LD;
        S_INT_LD:  state_ff <= divLoad ? S_INT_DV : S_FLT_LD;
        S_INT_DV:  state_ff <= divBusy_ff ? S_INT_DV : S_FLT_LD;
        S_FLT_LD:  state_ff <= divLoad ? S_FLT_DV : S_OUT;
        S_FLT_DV:  state_ff <= divBusy_ff ? S_FLT_DV : S_OUT;
        S_OUT:     state_ff <= S_IDLE;
        default:   state_ff <= S_IDLE;
      endcase
    end
  end

  // Regulator states; held cleared while the regulator is off
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tgtSnap_ff     <= 16'h0000;
      fbSnap_ff      <= 16'h0000;
      softRampAcc_ff <= 32'sh0;
      integAcc_ff    <= '0;
      iTerm_ff       <= 32'sh0;
      dPrev_ff       <= 32'sh0;
      flt_ff         <= 32'sh0;
    end else if (!active) begin
      tgtSnap_ff     <= 16'h0000;
      fbSnap_ff      <= 16'h0000;
      softRampAcc_ff <= 32'sh0;
      integAcc_ff    <= '0;
      iTerm_ff       <= 32'sh0;
      dPrev_ff       <= 32'sh0;
      flt_ff         <= 32'sh0;
    end else begin
      case (state_ff)
        S_IDLE: begin
          if (tick) begin
            tgtSnap_ff <= tgtSel;
            fbSnap_ff  <= fbSel;
          end
        end
        S_RAMP_LD: begin
          if (!divLoad) begin
            softRampAcc_ff <= softRampAcc_ff + rampDiff;
          end
        end
        S_RAMP_DV: begin
          // Ramp step in Q8 per sample; the last step lands exactly
          if (!divBusy_ff) begin
            if (rampDiff > $signed(quot_ff[31:0])) begin
              softRampAcc_ff <= softRampAcc_ff + $signed(quot_ff[31:0]);
            end else if (rampDiff < -$signed(quot_ff[31:0])) begin
              softRampAcc_ff <= softRampAcc_ff - $signed(quot_ff[31:0]);
            end else begin
              softRampAcc_ff <= softRampAcc_ff + rampDiff;
            end
          end
        end
        S_INT_LD: begin
          // Anti-windup: the store is clamped so its quotient meets the limit
          if (divLoad) begin
            integAcc_ff <= accNext;
          end else begin
            integAcc_ff <= '0;
            iTerm_ff    <= 32'sh0;
          end
        end
        S_INT_DV: begin
          if (!divBusy_ff) begin
            iTerm_ff <= (integAcc_ff < 0) ? -$signed(quot_ff[31:0])
                                          : $signed(quot_ff[31:0]);
          end
        end
        S_FLT_LD: begin
          if (!divLoad) begin
            flt_ff <= limited;
          end
        end
        S_FLT_DV: begin
          if (!divBusy_ff) begin
            flt_ff <= (fltDiff < 0) ? flt_ff - $signed(quot_ff[31:0])
                                    : flt_ff + $signed(quot_ff[31:0]);
          end
        end
        S_OUT: begin
          dPrev_ff <= dIn;
        end
        default: begin
          dPrev_ff <= dPrev_ff;
        end
      endcase
    end
  end

  // Feedback loss timing in samples; a zero time detects at once
  assign lossBelow = (fbScaled < $signed({16'h0000, cfg_ff[IDX_LOSS_LVL]}) * WHOLE_PCT);
  assign lossHit   = lossBelow && (lossCnt_ff + 32'h0000_0001
                     >= 32'(cfg_ff[IDX_LOSS_TIME] * LOSS_SAMPLES));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lossCnt_ff <= 32'h0000_0000;
      lossInd_ff <= 1'b0;
    end else if (!active || cfg_ff[IDX_LOSS_SEL] == LOSS_OFF) begin
      lossCnt_ff <= 32'h0000_0000;
      lossInd_ff <= 1'b0;
    end else if (state_ff == S_OUT) begin
      lossCnt_ff <= (lossBelow && !lossHit) ? lossCnt_ff + 32'h0000_0001
                                            : (lossBelow ? lossCnt_ff : 32'h0000_0000);
      lossInd_ff <= lossHit;
    end
  end

  // Fault latch: a new detection wins over a software clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lossFault_ff <= 1'b0;
    end else if (active && state_ff == S_OUT && lossHit
                 && cfg_ff[IDX_LOSS_SEL] == LOSS_FAULT) begin
      lossFault_ff <= 1'b1;
    end else if (faultClear) begin
      lossFault_ff <= 1'b0;
    end
  end

  // Frequency reference: pass-through when off, regulator result when on
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      freqRefOut_ff <= 16'h0000;
      reverse_ff    <= 1'b0;
    end else if (!active) begin
      freqRefOut_ff <= freqRefIn;
      reverse_ff    <= 1'b0;
    end else if (state_ff == S_OUT) begin
      if (lossFault_ff) begin
        freqRefOut_ff <= 16'h0000;
        reverse_ff    <= 1'b0;
      end else if (outValue < 0) begin
        freqRefOut_ff <= (cfg_ff[IDX_REV_SEL] == REV_ALLOW) ? 16'(-outValue) : 16'h0000;
        reverse_ff    <= (cfg_ff[IDX_REV_SEL] == REV_ALLOW);
      end else begin
        freqRefOut_ff <= 16'(outValue);
        reverse_ff    <= 1'b0;
      end
    end
  end

  // Alarm is a registered copy so the port stays glitch free
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      conflict_ff <= 1'b0;
    end else begin
      conflict_ff <= conflict;
    end
  end

  assign prdata                 = prdata_ff;
  assign pready                 = pready_ff;
  assign pslverr                = pslverr_ff;
  assign freqRefOut             = freqRefOut_ff;
  assign reverseCmd             = reverse_ff;
  assign sourceConflictAlarm    = conflict_ff;
  assign feedbackLossIndication = lossInd_ff;
  assign feedbackLossFault      = lossFault_ff;

endmodule

// file: tb/pid_checker.sv
/*
  Port checker for the process PID regulator: APB timing and output flags.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module pid_checker (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic [15:0] freqRefOut,
  input wire logic        sourceConflictAlarm,
  input wire logic        feedbackLossIndication,
  input wire logic        feedbackLossFault
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // Setup then access phase; the answer must wait exactly one cycle
  sequence apbAccess;
    psel && !penable ##1 psel && penable;
  endsequence

  access_wait_a: assert property (apbAccess |-> !pready ##1 pready)
    else $error("APB answer not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel) && $past(penable))
    else $error("pready without a request");
  err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("pslverr outside answer or with data");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  reset_quiet_a: assert property ($rose(nrst) |-> freqRefOut == 16'h0 && !feedbackLossFault)
    else $error("outputs not quiet after reset");
  loss_flag_a: assert property ($rose(feedbackLossFault) |-> feedbackLossIndication)
    else $error("fault without loss indication");
  fault_zero_a: assert property ($rose(feedbackLossFault) |-> ##[0:400] freqRefOut == 16'h0)
    else $error("output not zero after fault");
endmodule

// file: tb/drive_side_model.sv
/*
  Far side: analog inputs and incoming frequency reference.
  Assumes the bench sets levels; values arrive synchronous to clock.
*/
`timescale 1ns/1ps
module drive_side_model (
  input  wire logic        clock,
  input  wire logic [15:0] oneSet,
  input  wire logic [15:0] twoSet,
  input  wire logic [15:0] refSet,
  output logic      [15:0] ainOne,
  output logic      [15:0] ainTwo,
  output logic      [15:0] refIn
);
  // Converter outputs register once, as a sampled front end would
  always_ff @(posedge clock) begin
    ainOne <= oneSet;
    ainTwo <= twoSet;
    refIn  <= refSet;
  end
endmodule

// file: tb/process_pid_regulator_tb.sv
/*
  Self-checking bench for the process PID regulator.
  Assumes a short sample period of 200 cycles and the drive side model.
*/
`timescale 1ns/1ps
module process_pid_regulator_tb;
  import pid_reg_pkg::*;
  logic        clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, rampBypass = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, reverseCmd, sourceConflictAlarm;
  logic        feedbackLossIndication, feedbackLossFault;
  logic [15:0] oneSet = 16'h0, twoSet = 16'h0, refSet = 16'h0, ainOne, ainTwo, refIn, freqRefOut;
  logic [32:0] expQ[$];
  int          badCount = 0, checkCount = 0;

  initial forever #5 clock = ~clock;

  process_pid_regulator #(.SAMPLE_CYCLES(200)) process_pid_regulator_inst (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analogInputOne(ainOne), .analogInputTwo(ainTwo), .freqRefIn(refIn),
    .rampBypass(rampBypass), .freqRefOut(freqRefOut), .reverseCmd(reverseCmd),
    .sourceConflictAlarm(sourceConflictAlarm), .feedbackLossIndication(feedbackLossIndication),
    .feedbackLossFault(feedbackLossFault));
  drive_side_model drive_side_model_inst (.clock(clock), .oneSet(oneSet), .twoSet(twoSet),
    .refSet(refSet), .ainOne(ainOne), .ainTwo(ainTwo), .refIn(refIn));

  task check(input string nm, input logic [32:0] e, input logic [32:0] s);
    checkCount++;
    if (s !== e) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One APB transfer; the trailing edge keeps two transfers from colliding
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task wr(input int idx, input logic [15:0] v);
    apb(1'b1, 12'(idx * 4), {16'h0, v});
  endtask

  task rd(input logic [11:0] a, input logic [32:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // Waits past a full sample and its evaluation, then compares flags and output
  task expectOut(input logic [32:0] e);
    repeat (420) @(posedge clock);
    @(negedge clock);
    check("output", e, {14'h0, feedbackLossFault, feedbackLossIndication, reverseCmd, freqRefOut});
  endtask

  // Waits until a sample moves the output, so ramp steps are counted one by one
  task nextOut(input logic [32:0] e);
    logic [15:0] old;
    old = freqRefOut;
    for (int i = 0; i < 420 && freqRefOut == old; i++) @(negedge clock);
    check("ramp", e, {14'h0, feedbackLossFault, feedbackLossIndication, reverseCmd, freqRefOut});
  endtask

  // Read answers are paired with the oldest noted expectation
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      check("prdata", expQ.pop_front(), {pslverr, prdata});
  end

  initial begin
    repeat (20000) @(posedge clock);
    badCount++;
    summarize();
  end

  initial begin
    refSet <= 16'($urandom(32'h107e) % 10001);
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < CFG_COUNT; i++) rd(12'(i * 4), {17'h0, CFG_RESET[i]});
    rd(12'h05c, {1'b1, 32'h0});
    rd(12'h002, {1'b1, 32'h0});
    // Idle regulator: reference passes straight through
    for (int i = 0; i < 4; i++) begin
      refSet <= 16'($urandom % 10001);
      repeat (3) @(posedge clock);
      @(negedge clock);
      check("passthrough", {17'h0, refSet}, {17'h0, freqRefOut});
      @(posedge clock);
    end
    wr(IDX_FB_SRC, 16'h0001);
    repeat (2) @(posedge clock);
    check("alarm", 33'h1, {32'h0, sourceConflictAlarm});
    wr(IDX_FB_SRC, 16'h0002);
    twoSet <= 16'd2000;
    oneSet <= 16'd4000;
    wr(IDX_CMD_SEL, CMD_SEL_PID);
    wr(IDX_TGT_SRC, SRC_INTERNAL);
    wr(IDX_TARGET, 16'd500);
    wr(IDX_TI, 16'h0);
    wr(IDX_MODE, 16'h0001);
    expectOut(33'd3000);
    wr(IDX_TGT_SRC, SRC_AIN_ONE);
    wr(IDX_FB_GAIN, 16'd50);
    expectOut(33'd3000);
    wr(IDX_MODE, 16'h0009);
    expectOut(33'd7000);
    wr(IDX_MODE, 16'h0003);
    expectOut(33'd0);
    wr(IDX_REV_SEL, REV_ALLOW);
    expectOut({16'h0, 1'b1, 16'd3000});
    wr(IDX_OUT_GAIN, 16'd20);
    wr(IDX_OLIM, 16'd2000);
    expectOut({16'h0, 1'b1, 16'd4000});
    wr(IDX_LOSS_LVL, 16'd50);
    wr(IDX_LOSS_TIME, 16'h0);
    wr(IDX_LOSS_SEL, LOSS_FAULT);
    repeat (420) @(posedge clock);
    @(negedge clock);
    check("loss", 33'h6_0000, {14'h0, feedbackLossFault, feedbackLossIndication, 1'b0, freqRefOut});
    // Warning mode keeps running once the latched fault is cleared
    wr(IDX_LOSS_SEL, 16'h0001);
    apb(1'b1, ADDR_STATUS, 32'h0000_0010);
    expectOut({16'h1, 1'b1, 16'd4000});
    // Ramp bypass jumps straight to the target; without it the target steps 1 % a sample
    wr(IDX_MODE, 16'h0001);
    wr(IDX_RAMP, 16'h0001);
    rampBypass <= 1'b1;
    oneSet     <= 16'd1800;
    expectOut({16'h1, 1'b0, 16'd1600});
    @(posedge clock);
    rampBypass <= 1'b0;
    oneSet     <= 16'd4000;
    nextOut({16'h1, 1'b0, 16'd1800});
    nextOut({16'h1, 1'b0, 16'd2000});
    @(posedge clock);
    rd(ADDR_STATUS, 33'h0_0000_000a);
    summarize();
  end
endmodule

bind process_pid_regulator pid_checker pid_checker_inst (
  .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .freqRefOut(freqRefOut),
  .sourceConflictAlarm(sourceConflictAlarm), .feedbackLossIndication(feedbackLossIndication),
  .feedbackLossFault(feedbackLossFault));
